// ### rtl/charger_status_fault_regs.v
`timescale 1ns/1ns
// What this block does
// - Bits 7:6 of 0x00 show the present charge state code.
// - Bit 5 of 0x00 is write-only ship request, reset 0.
// - Bit 4 of 0x00 flags push-button reset; clears after read.
// - Bit 3 of 0x00 timer fault stays; clears on chip-disable toggle.
// - Bit 2 of 0x00 reads input dynamic power management activity.
// - Bit 7 of 0x01 overvoltage stays set while condition persists.
// - Bit 6 of 0x01 undervoltage set once per event, clears on read.
// - Bit 5 of 0x01 battery lockout stays set while lockout exists.
// - Bit 4 of 0x01 overcurrent set on event, cleared after read.
// - Bits 3:0 of 0x01 are fault masks, reset 0.
// - Bit 7 of 0x02 enables temperature sensing, reset 1.
// - Bits 6:5 of 0x02 give the temperature fault code.
// - Bit 4 of 0x02 shows open sense input; stops charge if optioned and sensing enabled.
// - Bit 3 of 0x02 enables full interrupt; cleared means faults only.
// - Bit 2 of 0x02 masks the push-button wake condition.
// - Bit 1 of 0x02 masks the push-button reset condition.
// - Bit 0 of 0x02 masks the safety-timer fault.
// - Reads outside the map return 0xff.
// - Registers reached as serial slave at 7-bit address 0x6a.
`include "charger_regs_defines.vh"

module charger_status_fault_regs (
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire       scl_in,
   input  wire       sda_in,
   output wire       sda_out,
   output wire       sda_oe,
   input  wire [1:0] charge_state,
   input  wire       input_dpm_active,
   input  wire       chip_disable_pin,
   input  wire       system_switch_on,
   input  wire       input_overvoltage,
   input  wire       input_undervoltage,
   input  wire       battery_lockout,
   input  wire       battery_overcurrent_event,
   input  wire       pushbutton_reset_event,
   input  wire       pushbutton_wake_event,
   input  wire       safety_timer_event,
   input  wire [1:0] temp_fault_code,
   input  wire       temp_input_open,
   input  wire       factory_open_stop_option,
   output reg        ship_request,
   output reg        temp_sense_enable,
   output reg        charge_stop_open,
   output reg        pushbutton_reset_out,
   output reg        pushbutton_wake_out,
   output reg        safety_timer_fault_out,
   output reg        interrupt_pulse
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_PTR  = 3'h2;
   localparam [2:0] ST_WR   = 3'h3;
   localparam [2:0] ST_RD   = 3'h4;

   reg  [2:0] state;
   reg  [3:0] bit_cnt;
   reg  [7:0] shift;
   reg  [7:0] pointer;
   reg        is_read;
   reg        addr_hit;
   reg        master_nack;
   reg        sda_drive;
   reg        scl_q;
   reg        sda_q;
   reg        wr_stb;
   reg  [7:0] wr_addr;
   reg  [7:0] wr_data;
   reg        rd_stb;
   reg  [7:0] rd_addr;

   reg  [3:0] fault_masks;
   reg        int_enable;
   reg        wake_mask;
   reg        reset_mask;
   reg        timer_mask;

   reg        cd_q;
   reg        ov_q;
   reg        uv_q;
   reg        lock_q;
   reg        dpm_q;
   reg  [1:0] state_q;
   reg  [1:0] tcode_q;
   reg        primed;

   wire       reset_flag;
   wire       timer_flag;
   wire       ov_flag;
   wire       uv_flag;
   wire       lock_flag;
   wire       ocp_flag;

   wire       start_cond;
   wire       stop_cond;
   wire       scl_rise;
   wire       scl_fall;
   wire [7:0] status_byte;
   wire [7:0] fault_byte;
   wire [7:0] temp_byte;
   wire [7:0] next_byte;
   wire [1:0] tcode_shown;
   wire       cd_toggle;
   wire       uv_rise;
   wire       clr_status;
   wire       clr_fault;
   wire       fault_evt;
   wire       status_evt;

   function [7:0] read_byte;
      input [7:0] addr;
      input [7:0] b0;
      input [7:0] b1;
      input [7:0] b2;
      begin
         case (addr)
            `OFS_STATUS_SHIP: read_byte = b0;
            `OFS_FAULT_MASK:  read_byte = b1;
            `OFS_TEMP_CTRL:   read_byte = b2;
            default:          read_byte = `UNMAPPED_READ;
         endcase
      end
   endfunction

   function is_reg;
      input [7:0] addr;
      input [7:0] target;
      begin
         is_reg = (addr == target);
      end
   endfunction

   // Bus line edges; pins are sampled once, already synchronous
   assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
   assign scl_rise   = scl_in & ~scl_q;
   assign scl_fall   = ~scl_in & scl_q;

   // Open drain: only ever pull low
   assign sda_out = 1'b0;
   assign sda_oe  = sda_drive;

   assign next_byte = read_byte(pointer, status_byte, fault_byte, temp_byte);

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= ST_IDLE;
         bit_cnt     <= 4'h0;
         shift       <= 8'h00;
         pointer     <= 8'h00;
         is_read     <= 1'b0;
         addr_hit    <= 1'b0;
         master_nack <= 1'b0;
         sda_drive   <= 1'b0;
         wr_stb      <= 1'b0;
         wr_addr     <= 8'h00;
         wr_data     <= 8'h00;
         rd_stb      <= 1'b0;
         rd_addr     <= 8'h00;
      end else begin
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         if (start_cond) begin
            // Repeated start keeps the register pointer
            state     <= ST_ADDR;
            bit_cnt   <= `START_BIT_CNT;
            sda_drive <= 1'b0;
         end else if (stop_cond) begin
            state     <= ST_IDLE;
            sda_drive <= 1'b0;
         end else if (state != ST_IDLE) begin
            if (scl_rise) begin
               if (bit_cnt < `BITS_PER_BYTE) begin
                  if (state != ST_RD) begin
                     shift <= {shift[6:0], sda_in};
                  end
               end else if (state == ST_RD) begin
                  master_nack <= sda_in;
               end
            end else if (scl_fall) begin
               if (bit_cnt == `LAST_DATA_BIT) begin
                  bit_cnt <= `BITS_PER_BYTE;
                  case (state)
                     ST_ADDR: begin
                        addr_hit  <= (shift[7:1] == `SLAVE_ADDR);
                        sda_drive <= (shift[7:1] == `SLAVE_ADDR);
                        is_read   <= shift[0];
                     end
                     ST_PTR: begin
                        pointer   <= shift;
                        sda_drive <= 1'b1;
                     end
                     ST_WR: begin
                        wr_stb    <= 1'b1;
                        wr_addr   <= pointer;
                        wr_data   <= shift;
                        pointer   <= pointer + 8'h01;
                        sda_drive <= 1'b1;
                     end
                     ST_RD: begin
                        sda_drive <= 1'b0;
                     end
                     default: begin
                        sda_drive <= 1'b0;
                     end
                  endcase
               end else if (bit_cnt == `BITS_PER_BYTE) begin
                  bit_cnt   <= 4'h0;
                  sda_drive <= 1'b0;
                  case (state)
                     ST_ADDR: begin
                        if (!addr_hit) begin
                           state <= ST_IDLE;
                        end else if (is_read) begin
                           state     <= ST_RD;
                           shift     <= next_byte;
                           sda_drive <= ~next_byte[7];
                           rd_stb    <= 1'b1;
                           rd_addr   <= pointer;
                           pointer   <= pointer + 8'h01;
                        end else begin
                           state <= ST_PTR;
                        end
                     end
                     ST_PTR: begin
                        state <= ST_WR;
                     end
                     ST_WR: begin
                        state <= ST_WR;
                     end
                     ST_RD: begin
                        if (master_nack) begin
                           state <= ST_IDLE;
                        end else begin
                           shift     <= next_byte;
                           sda_drive <= ~next_byte[7];
                           rd_stb    <= 1'b1;
                           rd_addr   <= pointer;
                           pointer   <= pointer + 8'h01;
                        end
                     end
                     default: begin
                        state <= ST_IDLE;
                     end
                  endcase
               end else begin
                  bit_cnt <= bit_cnt + 4'h1;
                  if (state == ST_RD) begin
                     shift     <= {shift[6:0], 1'b0};
                     sda_drive <= ~shift[6];
                  end
               end
            end
         end
      end
   end

   // Control bits written by the host
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ship_request      <= `RST_SHIP;
         fault_masks       <= `RST_FAULT_MASKS;
         temp_sense_enable <= `RST_TEMP_SENSE_ENABLE;
         int_enable        <= `RST_INT_EN;
         wake_mask         <= `RST_WAKE_M;
         reset_mask        <= `RST_RESET_M;
         timer_mask        <= `RST_TIMER_M;
      end else if (wr_stb) begin
         if (is_reg(wr_addr, `OFS_STATUS_SHIP)) begin
            ship_request <= wr_data[`BIT_SHIP];
         end
         if (is_reg(wr_addr, `OFS_FAULT_MASK)) begin
            fault_masks <= wr_data[`MASK_HI:`MASK_LO];
         end
         if (is_reg(wr_addr, `OFS_TEMP_CTRL)) begin
            temp_sense_enable <= wr_data[`BIT_TEMP_SENSE_ENABLE];
            int_enable        <= wr_data[`BIT_INT_EN];
            wake_mask         <= wr_data[`BIT_WAKE_M];
            reset_mask        <= wr_data[`BIT_RESET_M];
            timer_mask        <= wr_data[`BIT_TIMER_M];
         end
      end
   end

   // A byte counts as read once it is loaded for shifting out
   assign clr_status = rd_stb & is_reg(rd_addr, `OFS_STATUS_SHIP);
   assign clr_fault  = rd_stb & is_reg(rd_addr, `OFS_FAULT_MASK);
   assign cd_toggle  = cd_q ^ chip_disable_pin;
   assign uv_rise    = input_undervoltage & ~uv_q;

   sticky_flag u_reset_flag (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set     (pushbutton_reset_event),
      .clr     (clr_status),
      .q       (reset_flag)
   );

   // Reading never clears it; only the pin toggle or power cycle
   sticky_flag u_timer_flag (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set     (safety_timer_event),
      .clr     (cd_toggle),
      .q       (timer_flag)
   );

   // Level set keeps it up across reads while the fault lasts
   sticky_flag u_ov_flag (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set     (input_overvoltage),
      .clr     (clr_fault),
      .q       (ov_flag)
   );

   sticky_flag u_uv_flag (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set     (uv_rise),
      .clr     (clr_fault),
      .q       (uv_flag)
   );

   sticky_flag u_lock_flag (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set     (battery_lockout),
      .clr     (clr_fault),
      .q       (lock_flag)
   );

   sticky_flag u_ocp_flag (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set     (battery_overcurrent_event),
      .clr     (clr_fault),
      .q       (ocp_flag)
   );

   // Disabled sensing reports a normal code
   assign tcode_shown = temp_sense_enable ? temp_fault_code
                                          : `TCODE_NORMAL;

   assign status_byte = {charge_state,
                         1'b0,
                         reset_flag,
                         timer_flag,
                         input_dpm_active,
                         chip_disable_pin,
                         system_switch_on};
   assign fault_byte  = {ov_flag, uv_flag, lock_flag, ocp_flag,
                         fault_masks};
   assign temp_byte   = {temp_sense_enable,
                         tcode_shown,
                         temp_input_open,
                         int_enable, wake_mask, reset_mask, timer_mask};

   // Unmasked fault events always interrupt; status only when enabled
   assign fault_evt =
      (input_overvoltage & ~ov_q & ~fault_masks[3]) |
      (uv_rise & ~fault_masks[2]) |
      (battery_lockout & ~lock_q & ~fault_masks[1]) |
      (battery_overcurrent_event & ~fault_masks[0]) |
      (safety_timer_event & ~timer_mask) |
      (pushbutton_reset_event & ~reset_mask) |
      (temp_sense_enable & (tcode_shown != tcode_q) &
       (tcode_shown != `TCODE_NORMAL)) |
      ((charge_state != state_q) & (charge_state == `STATE_FAULT));
   assign status_evt =
      (charge_state != state_q) |
      (input_dpm_active != dpm_q) |
      (pushbutton_wake_event & ~wake_mask);

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cd_q                   <= 1'b0;
         ov_q                   <= 1'b0;
         uv_q                   <= 1'b0;
         lock_q                 <= 1'b0;
         dpm_q                  <= 1'b0;
         state_q                <= 2'h0;
         tcode_q                <= `TCODE_NORMAL;
         primed                 <= 1'b0;
         interrupt_pulse        <= 1'b0;
         charge_stop_open       <= 1'b0;
         pushbutton_reset_out   <= 1'b0;
         pushbutton_wake_out    <= 1'b0;
         safety_timer_fault_out <= 1'b0;
      end else begin
         cd_q                   <= chip_disable_pin;
         ov_q                   <= input_overvoltage;
         uv_q                   <= input_undervoltage;
         lock_q                 <= battery_lockout;
         dpm_q                  <= input_dpm_active;
         state_q                <= charge_state;
         tcode_q                <= tcode_shown;
         primed                 <= 1'b1;
         // Edges against the reset samples are not real events
         interrupt_pulse        <= primed & (fault_evt |
                                   (int_enable & status_evt));
         charge_stop_open       <= temp_sense_enable & temp_input_open &
                                   factory_open_stop_option;
         pushbutton_reset_out   <= pushbutton_reset_event &
                                   ~reset_mask;
         pushbutton_wake_out    <= pushbutton_wake_event & ~wake_mask;
         safety_timer_fault_out <= timer_flag & ~timer_mask;
      end
   end

endmodule

// ### rtl/charger_regs_defines.vh
`ifndef CHARGER_REGS_DEFINES_VH
`define CHARGER_REGS_DEFINES_VH

// Serial slave address, 7-bit only
`define SLAVE_ADDR             7'h6a

// Register offsets
`define OFS_STATUS_SHIP        8'h00
`define OFS_FAULT_MASK         8'h01
`define OFS_TEMP_CTRL          8'h02
`define UNMAPPED_READ          8'hff

// charge_status_ship_ctrl fields
`define BIT_STATE_HI           7
`define BIT_STATE_LO           6
`define BIT_SHIP               5
`define BIT_RESET_FLAG         4
`define BIT_TIMER_FLAG         3
`define BIT_DPM                2
`define BIT_CD_LEVEL           1
`define BIT_SYS_SW             0
`define STATE_FAULT            2'h3

// fault_flags_masks fields
`define BIT_OV_FLAG            7
`define BIT_UV_FLAG            6
`define BIT_LOCK_FLAG          5
`define BIT_OCP_FLAG           4
`define MASK_LO                0
`define MASK_HI                3
`define RST_FAULT_MASKS        4'h0

// temp_sense_ctrl_masks fields
`define BIT_TEMP_SENSE_ENABLE              7
`define BIT_TCODE_HI           6
`define BIT_TCODE_LO           5
`define BIT_TOPEN              4
`define BIT_INT_EN             3
`define BIT_WAKE_M             2
`define BIT_RESET_M            1
`define BIT_TIMER_M            0
`define RST_TEMP_SENSE_ENABLE              1'b1
`define RST_INT_EN             1'b1
`define RST_WAKE_M             1'b0
`define RST_RESET_M            1'b0
`define RST_TIMER_M            1'b0
`define RST_SHIP               1'b0
`define TCODE_NORMAL           2'h0

// Serial engine
`define BITS_PER_BYTE          4'h8
`define LAST_DATA_BIT          4'h7
// The SCL fall that closes a start wraps this to 0
`define START_BIT_CNT          4'hf

`endif

// ### rtl/sticky_flag.v
`timescale 1ns/1ns
// Flag set by hardware, cleared by a clear pulse; set wins
module sticky_flag (
   input  wire sys_clk,
   input  wire rst_n,
   input  wire set,
   input  wire clr,
   output reg  q
);

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= 1'b0;
      end else begin
         q <= set | (q & ~clr);
      end
   end

endmodule

// ### tb/charger_status_fault_regs_asserts.sv
`timescale 1ns/1ns
module charger_status_fault_regs_asserts (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic chip_disable_pin,
   input wire logic pushbutton_reset_event,
   input wire logic pushbutton_wake_event,
   input wire logic safety_timer_event,
   input wire logic temp_input_open,
   input wire logic factory_open_stop_option,
   input wire logic ship_request,
   input wire logic temp_sense_enable,
   input wire logic charge_stop_open,
   input wire logic pushbutton_reset_out,
   input wire logic pushbutton_wake_out,
   input wire logic safety_timer_fault_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sda_const_a: assert property (sda_out == 1'b0)
      else $error("data pin value not held low");
   // Data may only move while the serial clock is low
   oe_scl_low_a: assert property ($changed(sda_oe) |->
      !scl_in && !$past(scl_in)) else $error("data moved with clock high");
   ship_change_a: assert property ($changed(ship_request) |-> !scl_in)
      else $error("ship request moved outside a write");
   ts_change_a: assert property ($changed(temp_sense_enable) |->
      !scl_in) else $error("sense enable moved outside a write");
   wake_cause_a: assert property (pushbutton_wake_out |->
      $past(pushbutton_wake_event)) else $error("wake out without event");
   reset_cause_a: assert property (pushbutton_reset_out |->
      $past(pushbutton_reset_event)) else $error("reset out without event");
   open_stop_a: assert property ((temp_sense_enable && temp_input_open
      && factory_open_stop_option) [*3] |-> charge_stop_open)
      else $error("open sense input did not stop charge");
   no_stop_a: assert property (!temp_input_open [*3] |->
      !charge_stop_open) else $error("charge stopped without open input");
   timer_out_a: assert property ($rose(safety_timer_fault_out) |->
      !scl_in || $past(safety_timer_event) || $past(safety_timer_event, 2))
      else $error("timer fault rose without event");
   timer_hold_a: assert property ($fell(safety_timer_fault_out) |->
      !scl_in || $past(chip_disable_pin) != $past(chip_disable_pin, 3))
      else $error("timer fault cleared without disable toggle");
endmodule

// ### tb/i2c_host_model.sv
`timescale 1ns/1ns
module i2c_host_model (
   input  wire logic sys_clk,
   input  wire logic sda_oe,
   output logic      scl,
   output wire logic sda_line
);
   logic pull_low;
   // Open drain with pull-up: a released line reads high
   assign sda_line = ~(pull_low | sda_oe);
   initial begin
      scl = 1'b1;
      pull_low = 1'b0;
   end
   task wait_n(input integer n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Phases of 4 cycles keep well above the 3-cycle minimum
   task clk_bit(input logic b, output logic r);
      @(posedge sys_clk);
      pull_low <= ~b;
      wait_n(4);
      scl <= 1'b1;
      wait_n(4);
      r = sda_line;
      scl <= 1'b0;
   endtask
   task start_cond;
      @(posedge sys_clk);
      pull_low <= 1'b0;
      wait_n(4);
      scl <= 1'b1;
      wait_n(4);
      pull_low <= 1'b1;
      wait_n(4);
      scl <= 1'b0;
   endtask
   task stop_cond;
      @(posedge sys_clk);
      pull_low <= 1'b1;
      wait_n(4);
      scl <= 1'b1;
      wait_n(4);
      pull_low <= 1'b0;
      wait_n(4);
   endtask
   task send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
      clk_bit(1'b1, r);
      ack = ~r;
   endtask
   task get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, r);
         d[i] = r;
      end
      clk_bit(last, r);
   endtask
   // 7-bit address followed by the direction bit
   task write_reg(input logic [6:0] dev, input logic [7:0] p,
                  input logic [7:0] d, output logic ok);
      logic a0, a1, a2;
      start_cond;
      send_byte({dev, 1'b0}, a0);
      send_byte(p, a1);
      send_byte(d, a2);
      stop_cond;
      ok = a0 & a1 & a2;
   endtask
   task read_reg(input logic [6:0] dev, input logic [7:0] p,
                 output logic [7:0] d, output logic ok);
      logic a0, a1, a2;
      start_cond;
      send_byte({dev, 1'b0}, a0);
      send_byte(p, a1);
      start_cond;
      send_byte({dev, 1'b1}, a2);
      get_byte(1'b1, d);
      stop_cond;
      ok = a0 & a1 & a2;
   endtask
endmodule

// ### tb/charger_status_fault_regs_tb_top.sv
`timescale 1ns/1ns
module charger_status_fault_regs_tb_top;
   logic sys_clk, rst_n, scl_in, sda_in, sda_out, sda_oe;
   logic [1:0] charge_state, temp_fault_code;
   logic input_dpm_active, chip_disable_pin, system_switch_on;
   logic input_overvoltage, input_undervoltage, battery_lockout;
   logic temp_input_open, factory_open_stop_option;
   logic ship_request, temp_sense_enable, charge_stop_open;
   logic pushbutton_reset_out, pushbutton_wake_out;
   logic safety_timer_fault_out, interrupt_pulse, ok;
   logic [3:0] ev;
   logic [7:0] int_cnt, out_cnt, base, d;
   integer error_cnt, check_count, cyc;

   charger_status_fault_regs charger_status_fault_regs_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .charge_state(charge_state),
      .input_dpm_active(input_dpm_active),
      .chip_disable_pin(chip_disable_pin),
      .system_switch_on(system_switch_on),
      .input_overvoltage(input_overvoltage),
      .input_undervoltage(input_undervoltage),
      .battery_lockout(battery_lockout),
      .battery_overcurrent_event(ev[0]), .pushbutton_reset_event(ev[1]),
      .pushbutton_wake_event(ev[2]), .safety_timer_event(ev[3]),
      .temp_fault_code(temp_fault_code), .temp_input_open(temp_input_open),
      .factory_open_stop_option(factory_open_stop_option),
      .ship_request(ship_request), .temp_sense_enable(temp_sense_enable),
      .charge_stop_open(charge_stop_open),
      .pushbutton_reset_out(pushbutton_reset_out),
      .pushbutton_wake_out(pushbutton_wake_out),
      .safety_timer_fault_out(safety_timer_fault_out),
      .interrupt_pulse(interrupt_pulse));
   i2c_host_model i2c_host_model_inst (
      .sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl_in), .sda_line(sda_in));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (interrupt_pulse === 1'b1) int_cnt <= int_cnt + 8'h01;
      if ((pushbutton_wake_out | pushbutton_reset_out) === 1'b1)
         out_cnt <= out_cnt + 8'h01;
      if (cyc == 40000) begin
         error_cnt++;
         complete_run;
      end
   end

   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] p, input logic [7:0] v);
      i2c_host_model_inst.write_reg(7'h6a, p, v, ok);
      check({7'h0, ok}, 8'h01);
   endtask
   task rd(input logic [7:0] p, input logic [7:0] e);
      i2c_host_model_inst.read_reg(7'h6a, p, d, ok);
      check(d, e);
      check({7'h0, ok}, 8'h01);
   endtask
   task pulse(input logic [3:0] m);
      @(posedge sys_clk) ev <= m;
      @(posedge sys_clk) ev <= 4'h0;
      repeat (3) @(posedge sys_clk);
   endtask
   task complete_run;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      {rst_n, ev, input_dpm_active, chip_disable_pin} = '0;
      {input_overvoltage, input_undervoltage, battery_lockout} = '0;
      {temp_fault_code, temp_input_open} = '0;
      {int_cnt, out_cnt, error_cnt, check_count, cyc} = '0;
      charge_state = 2'b01;
      system_switch_on = 1'b1;
      factory_open_stop_option = 1'b1;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd(8'h00, 8'h41);
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h88);
      check({6'h0, ship_request, temp_sense_enable}, 8'h01);
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk) begin
            charge_state <= i[1:0];
            input_dpm_active <= i[0];
         end
         rd(8'h00, {i[1:0], 3'b000, i[0], 2'b01});
      end
      rd(8'h03, 8'hff);
      i2c_host_model_inst.read_reg(7'h6b, 8'h00, d, ok);
      check({7'h0, ok}, 8'h00);
      wr(8'h00, 8'h20);
      check({7'h0, ship_request}, 8'h01);
      rd(8'h00, 8'hc5);
      wr(8'h00, 8'h00);
      check({7'h0, ship_request}, 8'h00);
      pulse(4'b0010);
      rd(8'h00, 8'hd5);
      rd(8'h00, 8'hc5);
      pulse(4'b1000);
      rd(8'h00, 8'hcd);
      rd(8'h00, 8'hcd);
      check({7'h0, safety_timer_fault_out}, 8'h01);
      @(posedge sys_clk) chip_disable_pin <= 1'b1;
      rd(8'h00, 8'hc7);
      wr(8'h02, 8'h89);
      pulse(4'b1000);
      rd(8'h00, 8'hcf);
      check({7'h0, safety_timer_fault_out}, 8'h00);
      @(posedge sys_clk) chip_disable_pin <= 1'b0;
      wr(8'h02, 8'h88);
      base = int_cnt;
      pulse(4'b0001);
      check(int_cnt - base, 8'h01);
      wr(8'h01, 8'h01);
      base = int_cnt;
      pulse(4'b0001);
      check(int_cnt - base, 8'h00);
      rd(8'h01, 8'h11);
      rd(8'h01, 8'h01);
      @(posedge sys_clk) begin
         input_overvoltage <= 1'b1;
         battery_lockout <= 1'b1;
         input_undervoltage <= 1'b1;
      end
      rd(8'h01, 8'he1);
      rd(8'h01, 8'ha1);
      @(posedge sys_clk) {input_overvoltage, battery_lockout} <= 2'b00;
      rd(8'h01, 8'ha1);
      rd(8'h01, 8'h01);
      @(posedge sys_clk) input_undervoltage <= 1'b0;
      @(posedge sys_clk) input_undervoltage <= 1'b1;
      rd(8'h01, 8'h41);
      wr(8'h01, 8'hfa);
      rd(8'h01, 8'h0a);
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk) temp_fault_code <= i[1:0];
         rd(8'h02, {1'b1, i[1:0], 1'b0, 4'h8});
      end
      @(posedge sys_clk) temp_input_open <= 1'b1;
      rd(8'h02, 8'hf8);
      check({7'h0, charge_stop_open}, 8'h01);
      @(posedge sys_clk) factory_open_stop_option <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check({7'h0, charge_stop_open}, 8'h00);
      @(posedge sys_clk) {temp_input_open, factory_open_stop_option} <= 2'b01;
      wr(8'h02, 8'h07);
      check({7'h0, temp_sense_enable}, 8'h00);
      rd(8'h02, 8'h07);
      base = int_cnt;
      @(posedge sys_clk) input_dpm_active <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check(int_cnt - base, 8'h00);
      base = out_cnt;
      pulse(4'b0110);
      check(out_cnt - base, 8'h00);
      wr(8'h02, 8'h88);
      base = out_cnt;
      pulse(4'b0110);
      check(out_cnt - base, 8'h01);
      base = int_cnt;
      @(posedge sys_clk) input_dpm_active <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check(int_cnt - base, 8'h01);
      complete_run;
   end
endmodule

bind charger_status_fault_regs charger_status_fault_regs_asserts
   charger_status_fault_regs_asserts_inst (
   .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .chip_disable_pin(chip_disable_pin),
   .pushbutton_reset_event(pushbutton_reset_event),
   .pushbutton_wake_event(pushbutton_wake_event),
   .safety_timer_event(safety_timer_event),
   .temp_input_open(temp_input_open),
   .factory_open_stop_option(factory_open_stop_option),
   .ship_request(ship_request), .temp_sense_enable(temp_sense_enable),
   .charge_stop_open(charge_stop_open),
   .pushbutton_reset_out(pushbutton_reset_out),
   .pushbutton_wake_out(pushbutton_wake_out),
   .safety_timer_fault_out(safety_timer_fault_out));
